// File: pcd_div_if.sv
// Carrier between the register file and one divider lane.
// Assumes both ends share the core clock.
interface pcd_div_if;

    // ==========================================================
    // Lane signals
    logic [3:0] high_len;   // High phase length minus one
    logic [3:0] low_len;    // Low phase length minus one
    logic       tick;       // One input clock rising edge seen
    logic       level;      // Divider output level

    // Register side
    modport ctrl (
        output high_len,
        output low_len,
        output tick,
        input  level
    );

    // Divider side
    modport lane (
        input  high_len,
        input  low_len,
        input  tick,
        output level
    );

endinterface : pcd_div_if

// File: pcd_divider.sv
// One programmable divider lane: counts input edges per phase.
// Assumes tick is a one-cycle pulse per rising input edge.
module pcd_divider (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Lane carrier
    pcd_div_if.lane   div
);

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       level_r;
    logic       level_nxt;
    logic [3:0] limit;

    // ==========================================================
    // Phase counting
    // Limit of the phase now running
    always_comb begin
        limit     = level_r ? div.high_len : div.low_len;
        cnt_nxt   = cnt_r;
        level_nxt = level_r;
        if (div.tick) begin
            if (cnt_r >= limit) begin
                cnt_nxt   = 4'h0;
                level_nxt = ~level_r;
            end else begin
                cnt_nxt   = cnt_r + 4'h1;
            end
        end
    end

    // Counter and level registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r   <= 4'h0;
            level_r <= pcd_pkg::LEVEL_RST;
        end else begin
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign div.level = level_r;

endmodule : pcd_divider

// File: pcd_pkg.sv
// Constants shared by the clock divider block and its divider lanes.
// Assumes a single core clock; every divider input is sampled on it.
package pcd_pkg;

    // ==========================================================
    // Register map
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam logic [7:0] OFS_SECOND_REF  = 8'h11;
    localparam logic [7:0] OFS_FIRST_REF   = 8'h12;
    localparam logic [7:0] OFS_FEEDBACK    = 8'h13;
    localparam logic [7:0] OFS_STATUS      = 8'h18;

    // ==========================================================
    // Field layout of a phase register
    localparam int         FIELD_W         = 4;
    localparam int         HIGH_LSB        = 4;
    localparam int         LOW_LSB         = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] PHASES_RST      = 8'h00;
    localparam logic [7:0] RDATA_RST       = 8'h00;
    localparam logic       LEVEL_RST       = 1'b1;

    // ==========================================================
    // Lane numbering
    localparam int         NUM_DIV         = 3;
    localparam int         LANE_FIRST_REF  = 0;
    localparam int         LANE_SECOND_REF = 1;
    localparam int         LANE_FEEDBACK   = 2;

    // Register index type: lane number plus a hit flag
    typedef struct packed {
        logic       hit;
        logic [1:0] lane;
    } pcd_sel_t;

endpackage : pcd_pkg

// File: pcd_pll_model.sv
// Loop side model: makes the three divider input clocks.
// Assumes the core clock; each input has PERIOD core cycles.
module pcd_pll_model #(parameter int PERIOD = 4) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Divider link
    output logic      [2:0] div_clk_out
);
    // ==========================================================
    // Input clocks, half high and half low
    int cnt_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r       <= 0;
            div_clk_out <= 3'h0;
        end else begin
            cnt_r       <= (cnt_r + 1) % PERIOD;
            div_clk_out <= {3{cnt_r < PERIOD / 2}};
        end
    end
endmodule : pcd_pll_model

// File: pcd_top.sv
// Three programmable clock dividers with their phase registers.
// Assumes divider inputs are synchronous to CORE_CLK_IN and slower
// than half its rate; registers are reached over a plain port.
//
// Design decision made here: strobed register access.
module pcd_top (
    // Clock and reset
    input  wire logic       CORE_CLK_IN,
    input  wire logic       RST_IN,
    // Register port
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    // Divider inputs and outputs
    input  wire logic [2:0] DIV_CLK_IN,
    output logic      [2:0] DIV_OUT
);

    // ==========================================================
    // Address decode
    function automatic pcd_pkg::pcd_sel_t decode(input logic [7:0] addr);
        pcd_pkg::pcd_sel_t s;
        s = '0;
        case (addr)
            pcd_pkg::OFS_FIRST_REF: begin
                s.hit  = 1'b1;
                s.lane = 2'(pcd_pkg::LANE_FIRST_REF);
            end
            pcd_pkg::OFS_SECOND_REF: begin
                s.hit  = 1'b1;
                s.lane = 2'(pcd_pkg::LANE_SECOND_REF);
            end
            pcd_pkg::OFS_FEEDBACK: begin
                s.hit  = 1'b1;
                s.lane = 2'(pcd_pkg::LANE_FEEDBACK);
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction : decode

    logic [7:0]        phases_r   [pcd_pkg::NUM_DIV];
    logic [7:0]        phases_nxt [pcd_pkg::NUM_DIV];
    logic [7:0]        rdata_nxt;
    logic [2:0]        clk_prev_r;
    logic [2:0]        levels;
    pcd_pkg::pcd_sel_t wsel;
    pcd_pkg::pcd_sel_t rsel;

    pcd_div_if lane_if [pcd_pkg::NUM_DIV] ();

    // ==========================================================
    // Register writes
    always_comb begin
        wsel = decode(ADDR_IN);
        for (int i = 0; i < pcd_pkg::NUM_DIV; i++) begin
            phases_nxt[i] = phases_r[i];
            if (WR_IN && wsel.hit && (wsel.lane == 2'(i))) begin
                phases_nxt[i] = WDATA_IN;
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always_comb begin
        rsel      = decode(ADDR_IN);
        rdata_nxt = 8'h00;
        if (RD_IN) begin
            if (rsel.hit) begin
                rdata_nxt = phases_r[rsel.lane];
            end else if (ADDR_IN == pcd_pkg::OFS_STATUS) begin
                rdata_nxt = {5'h00, levels};
            end
        end
    end

    // Register file and read port
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < pcd_pkg::NUM_DIV; i++) begin
                phases_r[i] <= pcd_pkg::PHASES_RST;
            end
            RDATA_OUT  <= pcd_pkg::RDATA_RST;
            clk_prev_r <= 3'h0;
            DIV_OUT    <= {pcd_pkg::NUM_DIV{pcd_pkg::LEVEL_RST}};
        end else begin
            for (int i = 0; i < pcd_pkg::NUM_DIV; i++) begin
                phases_r[i] <= phases_nxt[i];
            end
            RDATA_OUT  <= rdata_nxt;
            clk_prev_r <= DIV_CLK_IN;
            DIV_OUT    <= levels;
        end
    end

    // ==========================================================
    // Divider lanes
    for (genvar g = 0; g < pcd_pkg::NUM_DIV; g++) begin : g_lane
        // Field split and input edge pulse
        assign lane_if[g].high_len = phases_r[g][pcd_pkg::HIGH_LSB +: pcd_pkg::FIELD_W];
        assign lane_if[g].low_len  = phases_r[g][pcd_pkg::LOW_LSB +: pcd_pkg::FIELD_W];
        assign lane_if[g].tick     = DIV_CLK_IN[g] & ~clk_prev_r[g];
        assign levels[g]           = lane_if[g].level;

        pcd_divider u_div (
            .clk_in (CORE_CLK_IN),
            .rst_in (RST_IN),
            .div    (lane_if[g])
        );
    end

endmodule : pcd_top

// File: pcd_top_properties.sv
// Port checker for the clock divider block.
// Assumes it is bound to pcd_top and sees only its ports.
module pcd_top_properties (
    input wire logic       CORE_CLK_IN,
    input wire logic       RST_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic       WR_IN,
    input wire logic       RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic [2:0] DIV_CLK_IN,
    input wire logic [2:0] DIV_OUT
);
    // ==========================================================
    // Port relations
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    a_reset_high: assert property ($fell(RST_IN) |-> DIV_OUT == 3'h7)
        else $error("divider outputs not high after reset");
    a_first_step: assert property ($changed(DIV_OUT[0]) |->
        $past(DIV_CLK_IN[0], 2) && !$past(DIV_CLK_IN[0], 3))
        else $error("first divider moved without input edge");
    a_fb_step: assert property ($changed(DIV_OUT[2]) |->
        $past(DIV_CLK_IN[2], 2) && !$past(DIV_CLK_IN[2], 3))
        else $error("feedback divider moved without input edge");
    a_read_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property ($past(RD_IN) && $past(ADDR_IN) > 8'h18 |->
        RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_status_live: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h18 |->
        RDATA_OUT == {5'h00, DIV_OUT})
        else $error("status read differs from divider outputs");
    c_second_fall: cover property ($fell(DIV_OUT[1]));
    c_read_second: cover property (RD_IN && ADDR_IN == 8'h11);
    c_write: cover property (WR_IN);
endmodule : pcd_top_properties

bind pcd_top pcd_top_properties i_props (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .DIV_CLK_IN(DIV_CLK_IN), .DIV_OUT(DIV_OUT));

// File: testbench.sv
// Testbench for the clock divider block.
// Assumes the loop model drives all divider inputs.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals and instances
    localparam int P = 4;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] dclk;
    logic [2:0] dout;
    int         n_fail = 0;
    int         tests_run = 0;
    pcd_top i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DIV_CLK_IN(dclk), .DIV_OUT(dout));
    pcd_pll_model #(.PERIOD(P)) i_pll (.clk_in(clk), .rst_in(rst), .div_clk_out(dclk));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        check("rdata", rdata, exp);
    endtask : rd_chk
    // Core cycles of one high and one low phase of lane l
    task automatic meas(input int l, input logic [7:0] f);
        int n;
        for (int s = 0; s < 4; s++) begin
            n = 0;
            while (dout[l] === s[0] && n < 400) begin
                @(negedge clk);
                n++;
            end
            // Third wait spans a full low phase, fourth a full high phase
            if (s == 2) check("low", 8'(n), 8'((f[3:0] + 1) * P));
            if (s == 3) check("high", 8'(n), 8'((f[7:4] + 1) * P));
        end
    endtask : meas
    task automatic final_report;
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // ==========================================================
    // Watchdog
    initial begin
        #(25 * 20000);
        n_fail++;
        final_report();
    end
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 8'h11; a <= 8'h13; a++) rd_chk(8'(a), 8'h00);
        // Lanes toggle on every rising input edge from reset; all high at this read
        rd_chk(8'h18, 8'h07);
        meas(0, 8'h00);
        wr_reg(8'h20, 8'h5a);
        rd_chk(8'h20, 8'h00);
        wr_reg(8'h11, 8'h70);
        rd_chk(8'h11, 8'h70);
        meas(1, 8'h70);
        wr_reg(8'h13, 8'h33);
        rd_chk(8'h13, 8'h33);
        meas(2, 8'h33);
        wr_reg(8'h12, 8'h25);
        rd_chk(8'h12, 8'h25);
        meas(0, 8'h25);
        meas(0, 8'h25);
        final_report();
    end
endmodule : testbench
